// ==== crisq_cfg.svh ====
`ifndef CRISQ_CFG_SVH
`define CRISQ_CFG_SVH

// Stack window: upper address bits fixed, six live pointer bits
`define CRISQ_SP_WIDTH      6
`define CRISQ_SP_TOP        6'h3f
`define CRISQ_STACK_BASE    16'h00c0
// Bytes stacked per call and per interrupt entry
`define CRISQ_CALL_BYTES    3'h2
`define CRISQ_INT_BYTES     3'h5
// Vector addresses (high byte location of each pair)
`define CRISQ_VEC_RESET     16'hfffe
`define CRISQ_VEC_SWI       16'hfffc
`define CRISQ_VEC_DECODER   16'hfffa
`define CRISQ_VEC_EXT       16'hfff8
`define CRISQ_VEC_KEY       16'hfff6
`define CRISQ_VEC_TIMER     16'hfff4
`define CRISQ_VEC_SERIAL    16'hfff2
`define CRISQ_VEC_RTC       16'hfff0
// Flag register layout
`define CRISQ_FLAG_C        0
`define CRISQ_FLAG_Z        1
`define CRISQ_FLAG_N        2
`define CRISQ_FLAG_I        3
`define CRISQ_FLAG_H        4
`define CRISQ_FLAG_ONES     3'h7
// Number of maskable hardware sources
`define CRISQ_NUM_SRC       6

`endif

// ==== crisq_pkg.sv ====
package crisq_pkg;

    // Sequencer states
    typedef enum logic [3:0] {
        CRISQ_RESET_VEC_HI = 4'h0,
        CRISQ_RESET_VEC_LO = 4'h1,
        CRISQ_RUN          = 4'h2,
        CRISQ_PUSH         = 4'h3,
        CRISQ_VEC_HI       = 4'h4,
        CRISQ_VEC_LO       = 4'h5,
        CRISQ_PULL         = 4'h6
    } crisq_state_t;

    // Indexed addressing modes
    typedef enum logic [1:0] {
        CRISQ_IDX_NONE = 2'h0,
        CRISQ_IDX_OFF8 = 2'h1,
        CRISQ_IDX_OFF16 = 2'h2
    } crisq_idx_t;

    // ALU operation class for flag update
    typedef enum logic [2:0] {
        CRISQ_OP_NONE  = 3'h0,
        CRISQ_OP_ADD   = 3'h1,
        CRISQ_OP_ARITH = 3'h2,
        CRISQ_OP_LOGIC = 3'h3,
        CRISQ_OP_LOAD  = 3'h4,
        CRISQ_OP_INCDEC = 3'h5,
        CRISQ_OP_SHIFT = 3'h6
    } crisq_op_t;

    // Result reported by the execution datapath
    typedef struct packed {
        crisq_op_t  op;
        logic [7:0] result;
        logic       carry;
        logic       half;
        logic       wr_acc;
        logic       wr_idx;
    } crisq_alu_t;

    // Memory access request toward the bus
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
        logic        read;
    } crisq_mem_t;

    // All sequencer state
    typedef struct packed {
        crisq_state_t state;
        logic [5:0]   sp;
        logic [15:0]  pc;
        logic [7:0]   acc;
        logic [7:0]   idx;
        logic [4:0]   flags;
        logic [2:0]   count;
        logic [15:0]  vec;
        logic         software_trap_instr;
        logic [7:0]   rdata;
    } crisq_regs_t;

endpackage

// ==== crisq_core.sv ====
`timescale 1ns/1ps
`include "crisq_cfg.svh"
module crisq_core
    import crisq_pkg::*;
#(
    parameter int NUM_SRC = `CRISQ_NUM_SRC
) (
    input  wire logic               clock_in,
    input  wire logic               rst_n_in,
    input  wire logic [NUM_SRC-1:0] irq_req_in,
    input  wire logic [NUM_SRC-1:0] irq_en_in,
    input  wire logic               instr_done_in,
    input  wire logic               fetch_in,
    input  wire logic               jump_in,
    input  wire logic [15:0]        jump_target_in,
    input  wire logic               call_in,
    input  wire logic               software_trap_instr_in,
    input  wire logic               interrupt_return_instr_in,
    input  wire logic               mask_clear_instr_in,
    input  wire logic               wait_instr_in,
    input  wire logic               mask_set_instr_in,
    input  wire logic               stack_pointer_reset_instr_in,
    input  wire logic               push_in,
    input  wire logic               pull_in,
    input  wire logic [7:0]         push_data_in,
    input  wire crisq_alu_t         alu_in,
    input  wire crisq_idx_t         idx_mode_in,
    input  wire logic [15:0]        idx_offset_in,
    input  wire logic [7:0]         mem_rdata_in,
    input  wire logic               mem_ready_in,
    output crisq_mem_t              mem_out,
    output logic [15:0]             idx_addr_out,
    output logic [15:0]             pc_out,
    output logic [15:0]             sp_addr_out,
    output logic [7:0]              acc_out,
    output logic [7:0]              idx_out,
    output logic [7:0]              condition_flag_register_out,
    output logic                    seq_busy_out,
    output logic [15:0]             vector_out
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Full stack address from the six live pointer bits
    function automatic logic [15:0] stack_addr(input logic [5:0] sp);
        stack_addr = `CRISQ_STACK_BASE | {10'h000, sp};
    endfunction

    // Service vector for the highest-priority pending source
    function automatic logic [15:0] pick_vector(input logic [NUM_SRC-1:0] pend);
        logic [15:0] v;
        v = `CRISQ_VEC_RTC;
        // Source 0 has the highest vector, so scan from the top down and let source 0 write last
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                v = `CRISQ_VEC_DECODER - {11'h000, 4'(i), 1'b0};
            end
        end
        pick_vector = v;
    endfunction

    // ************************************************************
    // State
    // ************************************************************

    crisq_regs_t        r_q;
    crisq_regs_t        r_d;
    logic [NUM_SRC-1:0] pending;
    logic [7:0]         stack_byte;
    logic [7:0]         full_flags;
    logic [16:0]        idx_sum;
    logic               entry_req;
    logic               last_byte;

    // Requests enabled locally and globally unmasked
    // Sources are level flags, so a masked request simply waits here
    assign pending = irq_req_in & irq_en_in & {NUM_SRC{~r_q.flags[`CRISQ_FLAG_I]}};
    assign full_flags = {`CRISQ_FLAG_ONES, r_q.flags};

    // Entry wanted at the end of an instruction; a trap ignores the mask
    assign entry_req = instr_done_in && (software_trap_instr_in || (|pending));

    // Fifth byte of a stacking or unstacking run
    assign last_byte = (r_q.count == `CRISQ_INT_BYTES - 3'h1);

    // Indexed operand address
    always_comb begin
        idx_sum = 17'h00000;
        unique case (idx_mode_in)
            CRISQ_IDX_OFF8:  idx_sum = {9'h000, idx_offset_in[7:0]} + {9'h000, r_q.idx};
            CRISQ_IDX_OFF16: idx_sum = {1'b0, idx_offset_in} + {9'h000, r_q.idx};
            default:         idx_sum = {9'h000, r_q.idx};
        endcase
    end

    // Byte to stack on interrupt entry: PC lo, PC hi, X, A, flags
    always_comb begin
        unique case (r_q.count)
            3'h0:    stack_byte = r_q.pc[7:0];
            3'h1:    stack_byte = r_q.pc[15:8];
            3'h2:    stack_byte = r_q.idx;
            3'h3:    stack_byte = r_q.acc;
            default: stack_byte = full_flags;
        endcase
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // One process walks the reset vector fetch, normal running, the
    // five-byte stacking run, the vector fetch and the unstacking run.
    // Outside RUN the instruction-side inputs are ignored, so a request
    // that arrives while the sequencer is busy must be held by its source.
    // Every memory step outside RUN waits for ready, so slow memory only stretches it.
    always_comb begin
        r_d = r_q;
        unique case (r_q.state)
            CRISQ_RESET_VEC_HI: begin
                if (mem_ready_in) begin
                    // High byte parked in the read buffer; vector stays visible
                    r_d.rdata     = mem_rdata_in;
                    r_d.state     = CRISQ_RESET_VEC_LO;
                end
            end
            CRISQ_RESET_VEC_LO: begin
                if (mem_ready_in) begin
                    r_d.pc    = {r_q.rdata, mem_rdata_in};
                    r_d.state = CRISQ_RUN;
                end
            end
            CRISQ_RUN: begin
                // Program counter advance or load
                if (jump_in) begin
                    r_d.pc = jump_target_in;
                end else if (fetch_in) begin
                    r_d.pc = r_q.pc + 16'h0001;
                end
                // Data register writes
                if (alu_in.wr_acc) begin
                    r_d.acc = alu_in.result;
                end
                if (alu_in.wr_idx) begin
                    r_d.idx = alu_in.result;
                end
                // Condition flags
                if (alu_in.op != CRISQ_OP_NONE) begin
                    r_d.flags[`CRISQ_FLAG_Z] = (alu_in.result == 8'h00);
                    if (alu_in.op != CRISQ_OP_LOAD) begin
                        r_d.flags[`CRISQ_FLAG_N] = alu_in.result[7];
                    end else begin
                        r_d.flags[`CRISQ_FLAG_N] = alu_in.result[7];
                    end
                    if (alu_in.op == CRISQ_OP_ADD) begin
                        r_d.flags[`CRISQ_FLAG_H] = alu_in.half;
                    end
                    if (alu_in.op != CRISQ_OP_INCDEC && alu_in.op != CRISQ_OP_LOAD) begin
                        r_d.flags[`CRISQ_FLAG_C] = alu_in.carry;
                    end
                end
                if (mask_clear_instr_in || wait_instr_in) begin
                    r_d.flags[`CRISQ_FLAG_I] = 1'b0;
                end else if (mask_set_instr_in) begin
                    r_d.flags[`CRISQ_FLAG_I] = 1'b1;
                end
                // Stack pointer moves, wrapping within 64 bytes
                if (stack_pointer_reset_instr_in) begin
                    r_d.sp = `CRISQ_SP_TOP;
                end else if (push_in) begin
                    r_d.sp = r_q.sp - 6'h01;
                end else if (pull_in) begin
                    r_d.sp = r_q.sp + 6'h01;
                end
                // Sequencer entry points at instruction end
                // Return wins: it is itself the instruction that completes
                if (interrupt_return_instr_in) begin
                    r_d.count = 3'h0;
                    r_d.sp    = r_q.sp + 6'h01;
                    r_d.state = CRISQ_PULL;
                end else if (entry_req) begin
                    r_d.software_trap_instr   = software_trap_instr_in;
                    r_d.count = 3'h0;
                    r_d.state = CRISQ_PUSH;
                end
            end
            CRISQ_PUSH: begin
                if (mem_ready_in) begin
                    r_d.sp    = r_q.sp - 6'h01;
                    r_d.count = r_q.count + 3'h1;
                    if (last_byte) begin
                        // Mask rises with the flags byte, so the stacked copy keeps the old mask
                        r_d.flags[`CRISQ_FLAG_I] = 1'b1;
                        // Priority chosen after stacking; trap wins as current instruction
                        r_d.vec   = r_q.software_trap_instr ? `CRISQ_VEC_SWI
                                            : pick_vector(irq_req_in & irq_en_in);
                        r_d.state = CRISQ_VEC_HI;
                    end
                end
            end
            CRISQ_VEC_HI: begin
                if (mem_ready_in) begin
                    r_d.rdata = mem_rdata_in;
                    r_d.state = CRISQ_VEC_LO;
                end
            end
            CRISQ_VEC_LO: begin
                if (mem_ready_in) begin
                    r_d.pc    = {r_q.rdata, mem_rdata_in};
                    r_d.state = CRISQ_RUN;
                end
            end
            CRISQ_PULL: begin
                // Pull order: flags, A, X, PC hi, PC lo
                if (mem_ready_in) begin
                    unique case (r_q.count)
                        3'h0:    r_d.flags = mem_rdata_in[4:0];
                        3'h1:    r_d.acc = mem_rdata_in;
                        3'h2:    r_d.idx = mem_rdata_in;
                        3'h3:    r_d.pc[15:8] = mem_rdata_in;
                        default: r_d.pc[7:0] = mem_rdata_in;
                    endcase
                    r_d.count = r_q.count + 3'h1;
                    // Pre-increment: the last pull leaves the pointer on the freed byte
                    if (last_byte) begin
                        r_d.state = CRISQ_RUN;
                    end else begin
                        r_d.sp = r_q.sp + 6'h01;
                    end
                end
            end
            default: r_d.state = CRISQ_RESET_VEC_HI;
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // Accumulator and index keep their value through reset
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            r_q.state <= CRISQ_RESET_VEC_HI;
            r_q.sp    <= `CRISQ_SP_TOP;
            r_q.flags[`CRISQ_FLAG_I] <= 1'b1;
            r_q.count <= 3'h0;
            r_q.vec   <= `CRISQ_VEC_RESET;
            r_q.software_trap_instr   <= 1'b0;
            r_q.acc   <= r_q.acc;
            r_q.idx   <= r_q.idx;
        end else begin
            r_q <= r_d;
        end
        // Reset touches only the mask among the flags; PC, the read buffer
        // and the other flags are left as they were
        if (!rst_n_in) begin
            r_q.pc    <= r_q.pc;
            r_q.rdata <= r_q.rdata;
            r_q.flags[`CRISQ_FLAG_H] <= r_q.flags[`CRISQ_FLAG_H];
            r_q.flags[`CRISQ_FLAG_N] <= r_q.flags[`CRISQ_FLAG_N];
            r_q.flags[`CRISQ_FLAG_Z] <= r_q.flags[`CRISQ_FLAG_Z];
            r_q.flags[`CRISQ_FLAG_C] <= r_q.flags[`CRISQ_FLAG_C];
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Memory request per state
    always_comb begin
        mem_out = '0;
        unique case (r_q.state)
            CRISQ_RESET_VEC_HI: begin
                mem_out.addr = `CRISQ_VEC_RESET;
                mem_out.read = 1'b1;
            end
            CRISQ_RESET_VEC_LO: begin
                mem_out.addr = `CRISQ_VEC_RESET + 16'h0001;
                mem_out.read = 1'b1;
            end
            CRISQ_PUSH: begin
                mem_out.addr  = stack_addr(r_q.sp);
                mem_out.wdata = stack_byte;
                mem_out.write = 1'b1;
            end
            CRISQ_VEC_HI: begin
                mem_out.addr = r_q.vec;
                mem_out.read = 1'b1;
            end
            CRISQ_VEC_LO: begin
                mem_out.addr = r_q.vec + 16'h0001;
                mem_out.read = 1'b1;
            end
            CRISQ_PULL: begin
                mem_out.addr = stack_addr(r_q.sp);
                mem_out.read = 1'b1;
            end
            default: begin
                mem_out.addr  = stack_addr(r_q.sp);
                mem_out.wdata = push_data_in;
                mem_out.write = push_in | call_in;
            end
        endcase
    end

    // Register views and status straight from the state
    // The 17th bit of the indexed sum is dropped: addresses wrap in 64K
    assign idx_addr_out = idx_sum[15:0];
    assign pc_out       = r_q.pc;
    assign sp_addr_out  = stack_addr(r_q.sp);
    assign acc_out      = r_q.acc;
    assign idx_out      = r_q.idx;
    assign condition_flag_register_out = full_flags;
    assign seq_busy_out = (r_q.state != CRISQ_RUN);
    assign vector_out   = r_q.vec;

endmodule // crisq_core

// ==== crisq_core_properties.sv ====
`timescale 1ns/1ps
// ****************************************
// Port-level checks of the sequencer
// ****************************************
module crisq_core_properties
    import crisq_pkg::*;
#(
    parameter int NUM_SRC = 6
) (
    input wire logic               clock_in,
    input wire logic               rst_n_in,
    input wire logic [NUM_SRC-1:0] irq_req_in,
    input wire logic [NUM_SRC-1:0] irq_en_in,
    input wire logic               instr_done_in,
    input wire logic               fetch_in,
    input wire logic               jump_in,
    input wire logic               push_in,
    input wire logic               mask_clear_instr_in,
    input wire logic               software_trap_instr_in,
    input wire crisq_idx_t         idx_mode_in,
    input wire crisq_mem_t         mem_out,
    input wire logic [15:0]        idx_addr_out,
    input wire logic [15:0]        pc_out,
    input wire logic [15:0]        sp_addr_out,
    input wire logic [7:0]         idx_out,
    input wire logic [7:0]         condition_flag_register_out,
    input wire logic               seq_busy_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    a_stack_window: assert property (sp_addr_out[15:6] == 10'h003)
        else $error("stack address left its window");
    a_flag_ones: assert property (condition_flag_register_out[7:5] == 3'h7)
        else $error("upper flag bits not ones");
    a_reset_state: assert property ($rose(rst_n_in) |->
        sp_addr_out == 16'h00ff && condition_flag_register_out[3])
        else $error("reset did not load stack top and mask");
    a_reset_vector: assert property ($rose(rst_n_in) |->
        mem_out.read && mem_out.addr == 16'hfffe)
        else $error("reset does not fetch its vector");
    a_push_decrement: assert property (push_in && !seq_busy_out |=>
        sp_addr_out[5:0] == $past(sp_addr_out[5:0]) - 6'h01)
        else $error("push did not step pointer down");
    a_entry_stacks: assert property (instr_done_in && !seq_busy_out &&
        !condition_flag_register_out[3] && |(irq_req_in & irq_en_in) |=>
        seq_busy_out && mem_out.write && mem_out.addr == $past(sp_addr_out))
        else $error("entry did not push at free stack byte");
    a_masked_pending: assert property (instr_done_in && !seq_busy_out &&
        condition_flag_register_out[3] && !software_trap_instr_in |=> !seq_busy_out)
        else $error("masked request was taken");
    a_mask_before_vec: assert property (seq_busy_out && mem_out.read &&
        mem_out.addr[15:4] == 12'hfff |-> condition_flag_register_out[3])
        else $error("vector read with mask clear");
    a_fetch_advance: assert property (fetch_in && !jump_in && !seq_busy_out &&
        !instr_done_in |=> pc_out == $past(pc_out) + 16'h0001)
        else $error("fetch did not advance counter");
    a_idx_plain: assert property (idx_mode_in == CRISQ_IDX_NONE |->
        idx_addr_out == {8'h00, idx_out})
        else $error("plain indexed address wrong");
    a_mask_clear: assert property (mask_clear_instr_in && !seq_busy_out |=>
        !condition_flag_register_out[3])
        else $error("mask clear had no effect");
endmodule // crisq_core_properties

bind crisq_core crisq_core_properties #(.NUM_SRC(NUM_SRC)) u_props (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .irq_req_in(irq_req_in),
    .irq_en_in(irq_en_in), .instr_done_in(instr_done_in), .fetch_in(fetch_in),
    .jump_in(jump_in), .push_in(push_in), .mask_clear_instr_in(mask_clear_instr_in),
    .software_trap_instr_in(software_trap_instr_in), .idx_mode_in(idx_mode_in),
    .mem_out(mem_out), .idx_addr_out(idx_addr_out), .pc_out(pc_out),
    .sp_addr_out(sp_addr_out), .idx_out(idx_out), .seq_busy_out(seq_busy_out),
    .condition_flag_register_out(condition_flag_register_out)
);

// ==== crisq_mem_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Memory answering stack and vector reads
// ****************************************
module crisq_mem_model
    import crisq_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       slow_in,
    input  wire crisq_mem_t mem_in,
    output logic            mem_ready_out,
    output logic [7:0]      mem_rdata_out
);
    logic [7:0] stack_q [0:63];
    logic       wait_q;
    logic [7:0] last_q;
    // Slow mode inserts one idle cycle per access
    assign mem_ready_out = (mem_in.read || mem_in.write) && (!slow_in || wait_q);
    // Vector high byte 4x, low 00; idle data is the inverse of the last byte
    assign mem_rdata_out = !mem_ready_out ? ~last_q :
        mem_in.addr[15:4] == 12'hfff ? (mem_in.addr[0] ? 8'h00 : {4'h4, mem_in.addr[3:0]}) :
        stack_q[mem_in.addr[5:0]];
    // Store pushes and track the wait state
    always_ff @(posedge clock_in) begin
        wait_q <= rst_n_in && (mem_in.read || mem_in.write) && !mem_ready_out;
        if (mem_ready_out && mem_in.write) begin
            stack_q[mem_in.addr[5:0]] <= mem_in.wdata;
        end
        if (mem_ready_out) begin
            last_q <= mem_rdata_out;
        end
    end
endmodule // crisq_mem_model

// ==== crisq_core_tb.sv ====
`timescale 1ns/1ps
`define check_eq(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
// ****************************************
// Sequencer testbench
// ****************************************
module crisq_core_tb
    import crisq_pkg::*;
;
    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [5:0]  irq_req = '0, irq_en = '0;
    logic        done = 0, fetch = 0, jump = 0, call = 0, software_trap_instr = 0, interrupt_return_instr = 0;
    logic        mclr = 0, wait_i = 0, mset = 0, sprst = 0, push = 0, pull = 0, slow = 0;
    logic [15:0] jtgt = '0, ioff = '0, saved_sp;
    logic [7:0]  pdata = 8'h5a, rdata, acc, idx, condition_flag_register;
    logic [15:0] idx_addr, pc, sp_addr, vec;
    crisq_alu_t  alu = '0;
    crisq_idx_t  imode = CRISQ_IDX_OFF16;
    crisq_mem_t  mem;
    logic        ready, busy;
    int          mismatches = 0, compares = 0, cycles = 0;

    crisq_core #(.NUM_SRC(6)) dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .irq_req_in(irq_req), .irq_en_in(irq_en),
        .instr_done_in(done), .fetch_in(fetch), .jump_in(jump), .jump_target_in(jtgt),
        .call_in(call), .software_trap_instr_in(software_trap_instr), .interrupt_return_instr_in(interrupt_return_instr),
        .mask_clear_instr_in(mclr), .wait_instr_in(wait_i), .mask_set_instr_in(mset),
        .stack_pointer_reset_instr_in(sprst), .push_in(push), .pull_in(pull),
        .push_data_in(pdata), .alu_in(alu), .idx_mode_in(imode), .idx_offset_in(ioff),
        .mem_rdata_in(rdata), .mem_ready_in(ready), .mem_out(mem), .idx_addr_out(idx_addr),
        .pc_out(pc), .sp_addr_out(sp_addr), .acc_out(acc), .idx_out(idx),
        .condition_flag_register_out(condition_flag_register), .seq_busy_out(busy), .vector_out(vec)
    );
    crisq_mem_model u_mem (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .slow_in(slow), .mem_in(mem),
        .mem_ready_out(ready), .mem_rdata_out(rdata)
    );

    // Clock and hang guard
    always #2 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    // Drop every one-cycle request and let the edge land
    task automatic pulse_end();
        @(posedge clock_in);
        {done, fetch, jump, call, software_trap_instr, interrupt_return_instr, mclr, wait_i, mset, sprst, push, pull} <= '0;
        alu <= '0;
        @(negedge clock_in);
    endtask
    // Wait for the sequencer to return to run state
    task automatic wait_idle();
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clock_in);
        `check_eq(busy, 1'b0)
    endtask
    // Hold reset pin low for ten cycles
    task automatic reset_dut();
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(negedge clock_in);
        wait_idle();
        `check_eq(pc, 16'h4e00)
        `check_eq(vec, 16'hfffe)
        `check_eq(condition_flag_register[3], 1'b1)
    endtask
    task automatic conclude();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Scenario sequence
    initial begin
        reset_dut();
        `check_eq(sp_addr, 16'h00ff)
        `check_eq(condition_flag_register[7:5], 3'h7)
        repeat (3) begin
            @(posedge clock_in); fetch <= 1; pulse_end();
        end
        `check_eq(pc, 16'h4e03)
        @(posedge clock_in); fetch <= 1; jump <= 1; jtgt <= 16'h1234; pulse_end();
        `check_eq(pc, 16'h1234)
        @(posedge clock_in); alu <= '{CRISQ_OP_ADD, 8'h80, 1'b1, 1'b1, 1'b1, 1'b0}; pulse_end();
        `check_eq(acc, 8'h80)
        `check_eq(condition_flag_register[4:0], 5'h1d)
        @(posedge clock_in); alu <= '{CRISQ_OP_INCDEC, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1}; pulse_end();
        `check_eq(condition_flag_register[2:0], 3'h3)
        @(posedge clock_in); alu <= '{CRISQ_OP_LOAD, 8'hf0, 1'b0, 1'b0, 1'b0, 1'b1}; pulse_end();
        `check_eq(condition_flag_register[2:0], 3'h5)
        @(posedge clock_in); imode <= CRISQ_IDX_NONE; ioff <= 16'hffff; @(negedge clock_in);
        `check_eq(idx_addr, 16'h00f0)
        @(posedge clock_in); imode <= CRISQ_IDX_OFF8; ioff <= 16'h0005; @(negedge clock_in);
        `check_eq(idx_addr, 16'h00f5)
        @(posedge clock_in); imode <= CRISQ_IDX_OFF16; ioff <= 16'h1234; @(negedge clock_in);
        `check_eq(idx_addr, 16'h1324)
        @(posedge clock_in); call <= 1; push <= 1; pulse_end();
        @(posedge clock_in); call <= 1; push <= 1; pulse_end();
        `check_eq(sp_addr, 16'h00fd)
        repeat (61) begin
            @(posedge clock_in); push <= 1; pulse_end();
        end
        `check_eq(sp_addr, 16'h00c0)
        @(posedge clock_in); push <= 1; pulse_end();
        `check_eq(sp_addr, 16'h00ff)
        @(posedge clock_in); pull <= 1; pulse_end();
        `check_eq(sp_addr, 16'h00c0)
        @(posedge clock_in); sprst <= 1; pulse_end();
        `check_eq(sp_addr, 16'h00ff)
        @(posedge clock_in); irq_req <= 6'h21; irq_en <= 6'h3f; done <= 1; pulse_end();
        `check_eq({busy, pc}, {1'b0, 16'h1234})
        @(posedge clock_in); mclr <= 1; pulse_end();
        `check_eq(condition_flag_register[3], 1'b0)
        saved_sp = sp_addr;
        @(posedge clock_in); done <= 1; pulse_end();
        wait_idle();
        `check_eq(pc, 16'h4a00)
        `check_eq(vec, 16'hfffa)
        `check_eq(u_mem.stack_q[6'h3b], 8'hf5)
        `check_eq(sp_addr, saved_sp - 16'h0005)
        `check_eq(condition_flag_register[3], 1'b1)
        `check_eq(u_mem.stack_q[saved_sp[5:0]], 8'h34)
        @(posedge clock_in); irq_req <= '0; interrupt_return_instr <= 1; pulse_end();
        wait_idle();
        `check_eq({pc, sp_addr, condition_flag_register[3]}, {16'h1234, saved_sp, 1'b0})
        @(posedge clock_in); irq_req <= 6'h02; irq_en <= 6'h3d; done <= 1; pulse_end();
        `check_eq({busy, pc}, {1'b0, 16'h1234})
        @(posedge clock_in); mset <= 1; slow <= 1; pulse_end();
        @(posedge clock_in); software_trap_instr <= 1; done <= 1; pulse_end();
        wait_idle();
        `check_eq({pc, condition_flag_register[3]}, {16'h4c00, 1'b1})
        `check_eq(vec, 16'hfffc)
        @(posedge clock_in); slow <= 0; irq_req <= '0; wait_i <= 1; pulse_end();
        `check_eq(condition_flag_register[3], 1'b0)
        reset_dut();
        `check_eq({acc, idx}, {8'h80, 8'hf0})
        conclude();
    end
endmodule // crisq_core_tb
